// file: logic/pllc_pkg.sv
// package for the pll control block: register map, fields, reset values
// assumes a 50 MHz system clock and a 32-bit avalon-mm slave port
package pllc_pkg;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] PLLC_OFS_CTRL   = 8'h00;
   localparam logic [7:0] PLLC_OFS_PHASE  = 8'h04;
   localparam logic [7:0] PLLC_OFS_DIVN   = 8'h08;
   localparam logic [7:0] PLLC_OFS_DIVM   = 8'h0C;
   localparam logic [7:0] PLLC_OFS_DIVO   = 8'h10;
   localparam logic [7:0] PLLC_OFS_DIVFB  = 8'h14;
   localparam logic [7:0] PLLC_OFS_DIVC0  = 8'h18;
   localparam logic [7:0] PLLC_OFS_STATUS = 8'h2C;
   localparam logic [7:0] PLLC_OFS_IRQ    = 8'h30;
   localparam logic [7:0] PLLC_OFS_MASK   = 8'h34;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int PLLC_CTRL_RUN     = 0;
   localparam int PLLC_CTRL_SEL_LO  = 4;
   localparam int PLLC_PH_CODE_LO   = 0;
   localparam int PLLC_PH_SEL_LO    = 4;
   localparam int PLLC_PH_APPLY     = 12;
   localparam int PLLC_ST_LOCK      = 0;
   localparam int PLLC_ST_CFG_ERR   = 1;
   localparam int PLLC_IRQ_LOCK_UP  = 0;
   localparam int PLLC_IRQ_LOCK_DN  = 1;
   localparam int PLLC_IRQ_PH_DONE  = 2;

   // ****************************************************************
   // reset values and limits
   // ****************************************************************
   localparam logic [7:0] PLLC_DIV_RST     = 8'h01;
   localparam logic [7:0] PLLC_DIVM_RST    = 8'h04;
   localparam int         PLLC_PROD_MAX    = 255;
   localparam int         PLLC_NUM_OUT     = 5;
   localparam int         PLLC_NUM_REF     = 4;
   localparam int         PLLC_NUM_IRQ     = 3;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int PLLC_CLK_MHZ        = 50;
   localparam int PLLC_RST_MIN_NS     = 10;
   localparam int PLLC_RST_CYC        =
      (PLLC_RST_MIN_NS * PLLC_CLK_MHZ + 999) / 1000 < 1 ? 1 :
      (PLLC_RST_MIN_NS * PLLC_CLK_MHZ + 999) / 1000;
   localparam int PLLC_LOCK_FILT_CYC  = 4;

   typedef enum logic [1:0] {
      PLLC_ST_HOLD   = 2'b00,
      PLLC_ST_ACQ    = 2'b01,
      PLLC_ST_LOCK_FLAG = 2'b11
   } pllc_state_e;

endpackage

// file: logic/pllc_top.sv
// pll control block: fabric-facing control of a frequency synthesis pll
// assumes one 50 MHz clock, avalon-mm register access, and an analog
// core that takes the control pins below and returns a raw lock level
//
// Contract
// - two-bit select picks one of four reference clocks, changeable live; the code changes it only while it holds the pll in reset
// - pll held reset while reset_n low, runs when released high
// - lock flag rises on lock, falls on detected loss of lock
// - raw lock is asynchronous and glitchy; synchronise and filter it
// - three-bit code delays output by code half post-divider cycles
// - five-bit selection chooses outputs hit by dynamic phase shift
// - phase apply high applies current code to selected outputs
// - pre-divider, feedback multiplier, post-divider, per-output dividers
// - fout equals fin times m times feedback divider over n times c
// - pfd is fin over n; post-divider clock is vco over o
// - five output clocks, each routable to the global clock network
`timescale 1ns/1ns
module pllc_top
   import pllc_pkg::*;
#(
   parameter int FILT_CYC = PLLC_LOCK_FILT_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        core_lock_raw,
   output logic [1:0]       ref_clk_select,
   output logic             pll_reset_n,
   output logic [2:0]       phase_code,
   output logic [4:0]       phase_out_select,
   output logic             phase_apply,
   output logic [7:0]       div_pre,
   output logic [7:0]       div_mult,
   output logic [7:0]       div_post,
   output logic [7:0]       feedback_out_divider,
   output logic [39:0]      div_out,
   output logic             lock_flag,
   output logic             irq
);

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic                     run;
   logic [1:0]               sel_req;
   logic [PLLC_NUM_IRQ-1:0]  irq_stat;
   logic [PLLC_NUM_IRQ-1:0]  irq_mask;
   logic [7:0]               div_c [PLLC_NUM_OUT];
   logic [2:0]               ph_code_req;
   logic [4:0]               ph_sel_req;
   logic                     ph_go;
   logic                     wr_acc;
   logic                     rd_acc;
   logic [7:0]               rst_cnt;
   logic                     sel_pending;
   pllc_state_e              state;
   logic                     lock_s1;
   logic                     lock_s2;
   logic [7:0]               filt_cnt;
   logic                     lock_filt;
   logic                     lock_filt_q;
   logic [PLLC_NUM_IRQ-1:0]  irq_ev;
   logic                     cfg_err;

   // byte-lane merge for a register field
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************************************
   // avalon-mm slave: one wait cycle, answer on the second edge
   // ****************************************************************
   logic req;
   assign req = (avs_read | avs_write) & ~wr_acc & ~rd_acc;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         wr_acc          <= 1'b0;
         rd_acc          <= 1'b0;
      end else begin
         wr_acc          <= avs_write & avs_waitrequest & ~wr_acc & ~rd_acc;
         rd_acc          <= avs_read & avs_waitrequest & ~wr_acc & ~rd_acc;
         avs_waitrequest <= ~req;
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         PLLC_OFS_CTRL: begin
            rd_mux[PLLC_CTRL_RUN] = run;
            rd_mux[PLLC_CTRL_SEL_LO +: 2] = sel_req;
         end
         PLLC_OFS_PHASE: begin
            rd_mux[PLLC_PH_CODE_LO +: 3] = ph_code_req;
            rd_mux[PLLC_PH_SEL_LO +: 5] = ph_sel_req;
         end
         PLLC_OFS_DIVN:   rd_mux[7:0] = div_pre;
         PLLC_OFS_DIVM:   rd_mux[7:0] = div_mult;
         PLLC_OFS_DIVO:   rd_mux[7:0] = div_post;
         PLLC_OFS_DIVFB:  rd_mux[7:0] = feedback_out_divider;
         PLLC_OFS_STATUS: begin
            rd_mux[PLLC_ST_LOCK] = lock_flag;
            rd_mux[PLLC_ST_CFG_ERR] = cfg_err;
            rd_mux[9:8] = state;
         end
         PLLC_OFS_IRQ:    rd_mux[PLLC_NUM_IRQ-1:0] = irq_stat;
         PLLC_OFS_MASK:   rd_mux[PLLC_NUM_IRQ-1:0] = irq_mask;
         default: begin
            for (int i = 0; i < PLLC_NUM_OUT; i++) begin
               if (avs_address == PLLC_OFS_DIVC0 + 8'(4 * i)) begin
                  rd_mux[7:0] = div_c[i];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & avs_waitrequest & ~wr_acc & ~rd_acc) begin
         avs_readdata <= rd_mux;
      end
   end

   // ****************************************************************
   // control and divider registers
   // ****************************************************************
   logic [31:0] wv;
   assign wv = merge(32'h0000_0000, avs_writedata, avs_byteenable);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run                  <= 1'b0;
         sel_req              <= 2'b00;
         div_pre              <= PLLC_DIV_RST;
         div_mult             <= PLLC_DIVM_RST;
         div_post             <= PLLC_DIV_RST;
         feedback_out_divider <= PLLC_DIV_RST;
         for (int i = 0; i < PLLC_NUM_OUT; i++) begin
            div_c[i] <= PLLC_DIV_RST;
         end
      end else if (wr_acc) begin
         case (avs_address)
            PLLC_OFS_CTRL: begin
               if (avs_byteenable[0]) begin
                  run     <= wv[PLLC_CTRL_RUN];
                  sel_req <= wv[PLLC_CTRL_SEL_LO +: 2];
               end
            end
            PLLC_OFS_DIVN:  if (avs_byteenable[0]) div_pre <= wv[7:0];
            PLLC_OFS_DIVM:  if (avs_byteenable[0]) div_mult <= wv[7:0];
            PLLC_OFS_DIVO:  if (avs_byteenable[0]) div_post <= wv[7:0];
            PLLC_OFS_DIVFB: begin
               if (avs_byteenable[0]) feedback_out_divider <= wv[7:0];
            end
            default: begin
               for (int i = 0; i < PLLC_NUM_OUT; i++) begin
                  if (avs_address == PLLC_OFS_DIVC0 + 8'(4 * i) &&
                      avs_byteenable[0]) begin
                     div_c[i] <= wv[7:0];
                  end
               end
            end
         endcase
      end
   end

   // five per-output divider buses, flattened
   genvar g;
   generate
      for (g = 0; g < PLLC_NUM_OUT; g++) begin : g_div
         assign div_out[g*8 +: 8] = div_c[g];
      end
   endgenerate

   // m*o*cfbk above the limit flags a bad setting and keeps pll in reset
   logic [23:0] prod;
   assign prod = 24'(div_mult) * 24'(div_post) * 24'(feedback_out_divider);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_err <= 1'b0;
      end else begin
         cfg_err <= prod > 24'(PLLC_PROD_MAX);
      end
   end

   // ****************************************************************
   // pll reset sequencing
   // ****************************************************************
   // a new reference selection forces a reset pulse of minimum width
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_clk_select <= 2'b00;
         sel_pending    <= 1'b0;
      end else if (sel_req != ref_clk_select && pll_reset_n) begin
         sel_pending    <= 1'b1;
      end else if (!pll_reset_n) begin
         ref_clk_select <= sel_req;
         sel_pending    <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pll_reset_n <= 1'b0;
         rst_cnt     <= 8'h00;
      end else if (!run || cfg_err || sel_pending ||
                   sel_req != ref_clk_select) begin
         pll_reset_n <= 1'b0;
         rst_cnt     <= 8'h00;
      end else if (rst_cnt < 8'(PLLC_RST_CYC)) begin
         rst_cnt     <= rst_cnt + 8'h01;
      end else begin
         pll_reset_n <= 1'b1;
      end
   end

   // ****************************************************************
   // lock synchronise and filter
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
      end else begin
         lock_s1 <= core_lock_raw;
         lock_s2 <= lock_s1;
      end
   end

   // filtered lock needs FILT_CYC steady samples to change
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filt_cnt  <= 8'h00;
         lock_filt <= 1'b0;
      end else if (!pll_reset_n) begin
         filt_cnt  <= 8'h00;
         lock_filt <= 1'b0;
      end else if (lock_s2 == lock_filt) begin
         filt_cnt  <= 8'h00;
      end else if (filt_cnt >= 8'(FILT_CYC - 1)) begin
         filt_cnt  <= 8'h00;
         lock_filt <= lock_s2;
      end else begin
         filt_cnt  <= filt_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= PLLC_ST_HOLD;
         lock_flag <= 1'b0;
      end else begin
         case (state)
            PLLC_ST_HOLD: begin
               lock_flag <= 1'b0;
               if (pll_reset_n) state <= PLLC_ST_ACQ;
            end
            PLLC_ST_ACQ: begin
               if (!pll_reset_n) begin
                  state <= PLLC_ST_HOLD;
               end else if (lock_filt) begin
                  state     <= PLLC_ST_LOCK_FLAG;
                  lock_flag <= 1'b1;
               end
            end
            PLLC_ST_LOCK_FLAG: begin
               if (!pll_reset_n || !lock_filt) begin
                  state     <= pll_reset_n ? PLLC_ST_ACQ : PLLC_ST_HOLD;
                  lock_flag <= 1'b0;
               end
            end
            default: begin
               state     <= PLLC_ST_HOLD;
               lock_flag <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // dynamic phase shift
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_code_req <= 3'h0;
         ph_sel_req  <= 5'h00;
         ph_go       <= 1'b0;
      end else begin
         ph_go <= 1'b0;
         if (wr_acc && avs_address == PLLC_OFS_PHASE) begin
            ph_code_req <= wv[PLLC_PH_CODE_LO +: 3];
            ph_sel_req  <= wv[PLLC_PH_SEL_LO +: 5];
            ph_go       <= wv[PLLC_PH_APPLY];
         end
      end
   end

   // code and selection are driven one cycle ahead of the apply pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_code       <= 3'h0;
         phase_out_select <= 5'h00;
         phase_apply      <= 1'b0;
      end else begin
         phase_apply      <= ph_go;
         if (wr_acc && avs_address == PLLC_OFS_PHASE) begin
            phase_code       <= wv[PLLC_PH_CODE_LO +: 3];
            phase_out_select <= wv[PLLC_PH_SEL_LO +: 5];
         end
      end
   end

   // ****************************************************************
   // interrupts
   // ****************************************************************
   assign irq_ev[PLLC_IRQ_LOCK_UP] = lock_filt & ~lock_filt_q;
   assign irq_ev[PLLC_IRQ_LOCK_DN] = lock_flag & state == PLLC_ST_LOCK_FLAG &
                                     ~lock_filt;
   assign irq_ev[PLLC_IRQ_PH_DONE] = phase_apply;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_filt_q <= 1'b0;
         irq_stat    <= '0;
         irq_mask    <= '0;
         irq         <= 1'b0;
      end else begin
         lock_filt_q <= lock_filt;
         // set wins over write-one-to-clear
         if (wr_acc && avs_address == PLLC_OFS_IRQ && avs_byteenable[0]) begin
            irq_stat <= (irq_stat & ~wv[PLLC_NUM_IRQ-1:0]) | irq_ev;
         end else begin
            irq_stat <= irq_stat | irq_ev;
         end
         if (wr_acc && avs_address == PLLC_OFS_MASK && avs_byteenable[0]) begin
            irq_mask <= wv[PLLC_NUM_IRQ-1:0];
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

endmodule

// file: bench/pllc_monitor.sv
// port checker for the pll control block
// assumes pllc_top with its avalon slave and raw lock input
`timescale 1ns/1ns
module pllc_monitor
   import pllc_pkg::*;
#(
   parameter int FILT_CYC = PLLC_LOCK_FILT_CYC
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic        core_lock_raw,
   input wire logic [1:0]  ref_clk_select,
   input wire logic        pll_reset_n,
   input wire logic [2:0]  phase_code,
   input wire logic [4:0]  phase_out_select,
   input wire logic        phase_apply,
   input wire logic        lock_flag
);
   logic wr_ph;
   assign wr_ph = avs_write && !avs_waitrequest &&
                  avs_address == PLLC_OFS_PHASE &&
                  avs_writedata[PLLC_PH_APPLY];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ****************************************************************
   // bus handshake
   // ****************************************************************
   a_wait_answer: assert property ((avs_read || avs_write) &&
      avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_idle: assert property (!avs_read && !avs_write |=>
      avs_waitrequest) else $error("answer without request");
   // ****************************************************************
   // pll reset and lock
   // ****************************************************************
   a_sel_in_reset: assert property (!$stable(ref_clk_select) |->
      !pll_reset_n && !$past(pll_reset_n)) else $error("select live");
   a_rst_width: assert property ($rose(pll_reset_n) |->
      !$past(pll_reset_n, 2)) else $error("pll reset too short");
   a_lock_in_reset: assert property (!pll_reset_n ##1 !pll_reset_n |->
      !lock_flag) else $error("lock during reset");
   a_lock_rise: assert property ($rose(lock_flag) |->
      $past(core_lock_raw, 4) && $past(pll_reset_n))
      else $error("lock without steady raw lock");
   a_lock_loss: assert property (!core_lock_raw [*8] |->
      ##[0:4] !lock_flag) else $error("loss of lock missed");
   // ****************************************************************
   // phase shift
   // ****************************************************************
   a_apply_cause: assert property (wr_ph |-> ##[1:3] phase_apply)
      else $error("phase apply missing");
   a_apply_stable: assert property (phase_apply |->
      $stable(phase_code) && $stable(phase_out_select))
      else $error("phase code moving at apply");
   a_apply_pulse: assert property (phase_apply |=> !phase_apply)
      else $error("apply longer than one cycle");
   c_lock: cover property ($rose(lock_flag));
   c_loss: cover property ($fell(lock_flag) && pll_reset_n);
   c_apply: cover property (phase_apply);
   c_sel: cover property (!$stable(ref_clk_select));
endmodule

bind pllc_top pllc_monitor #(.FILT_CYC(FILT_CYC)) u_mon (
   .clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .core_lock_raw(core_lock_raw), .ref_clk_select(ref_clk_select),
   .pll_reset_n(pll_reset_n), .phase_code(phase_code),
   .phase_out_select(phase_out_select), .phase_apply(phase_apply),
   .lock_flag(lock_flag));

// file: bench/pllc_core_model.sv
// behavioural analog pll core returning a raw lock level
// assumes the bench commands loss of lock and short glitches
`timescale 1ns/1ns
module pllc_core_model (
   input  wire logic       clk,
   input  wire logic       pll_reset_n,
   input  wire logic [1:0] ref_clk_select,
   input  wire logic [7:0] lock_cyc,
   input  wire logic       lose,
   input  wire logic       glitch,
   output logic            core_lock_raw
);
   logic [7:0] cnt;
   logic [1:0] sel_q;
   logic       lk;
   logic       gl;
   initial begin
      cnt = 8'h00;
      sel_q = 2'h0;
      lk = 1'b0;
      gl = 1'b0;
   end
   // lock drops at once on reset, reference change or commanded loss
   always @(posedge clk) begin
      sel_q <= ref_clk_select;
      if (!pll_reset_n || lose || sel_q != ref_clk_select) begin
         cnt <= 8'h00;
         lk <= 1'b0;
      end else if (cnt < lock_cyc) begin
         cnt <= cnt + 8'h01;
      end else begin
         lk <= 1'b1;
      end
   end
   // short low pulse off the clock grid
   always @(posedge glitch) begin
      #7 gl = 1'b1;
      #25 gl = 1'b0;
   end
   assign core_lock_raw = lk & ~gl;
endmodule

// file: bench/testbench.sv
// self-checking bench for the pll control block
// assumes pllc_top, the core model and the bound port monitor
`timescale 1ns/1ns
module testbench;
   import pllc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [3:0]  avs_byteenable = 4'hF;
   logic        avs_waitrequest, core_lock_raw, pll_reset_n;
   logic        phase_apply, lock_flag, irq;
   logic [1:0]  ref_clk_select;
   logic [2:0]  phase_code;
   logic [4:0]  phase_out_select;
   logic [7:0]  div_pre, div_mult, div_post, feedback_out_divider;
   logic [39:0] div_out;
   logic [7:0]  lock_cyc = 8'h14;
   logic        lose = 1'b0, glitch = 1'b0;
   int          n_mismatch = 0, cmp_count = 0, cyc = 0;

   always #10 clk = ~clk;

   pllc_top #(.FILT_CYC(4)) dut (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_lock_raw(core_lock_raw),
      .ref_clk_select(ref_clk_select), .pll_reset_n(pll_reset_n),
      .phase_code(phase_code), .phase_out_select(phase_out_select),
      .phase_apply(phase_apply), .div_pre(div_pre), .div_mult(div_mult),
      .div_post(div_post), .feedback_out_divider(feedback_out_divider),
      .div_out(div_out), .lock_flag(lock_flag), .irq(irq));
   pllc_core_model u_core (.clk(clk), .pll_reset_n(pll_reset_n),
      .ref_clk_select(ref_clk_select), .lock_cyc(lock_cyc), .lose(lose),
      .glitch(glitch), .core_lock_raw(core_lock_raw));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 40) n_mismatch++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask

   // w: 0 lock flag, 1 pll reset, 2 phase apply
   task automatic wait_for(input int w, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((w == 0 ? lock_flag : w == 1 ? pll_reset_n : phase_apply)
                 !== v && n < 300);
      if (n >= 300) n_mismatch++;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         final_report;
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      chk({div_pre, div_post, feedback_out_divider, div_mult}, 32'h01010104);
      chk(div_out, {5{8'h01}});
      chk({pll_reset_n, lock_flag, irq, avs_waitrequest}, 4'h1);
      rst <= 1'b0;
      wr(PLLC_OFS_DIVN, 32'h02);
      wr(PLLC_OFS_DIVM, 32'h08);
      wr(PLLC_OFS_DIVO, 32'h04);
      wr(PLLC_OFS_DIVFB, 32'h02);
      for (int i = 0; i < 5; i++) wr(8'(PLLC_OFS_DIVC0 + 4 * i), 32'(i + 4));
      @(posedge clk);
      chk({div_pre, div_mult, div_post, feedback_out_divider}, 32'h02080402);
      chk(div_out, 40'h0807060504);
      rdc(PLLC_OFS_DIVM, 32'hFF, 32'h08);
      wr(8'h3C, 32'hFFFFFFFF);
      rdc(8'h3C, 32'hFFFFFFFF, 32'h0);
      // lock acquisition raises the status bit and the interrupt
      wr(PLLC_OFS_MASK, 32'h7);
      wr(PLLC_OFS_CTRL, 32'h21);
      wait_for(1, 1'b1);
      chk(ref_clk_select, 2'h2);
      wait_for(0, 1'b1);
      rdc(PLLC_OFS_STATUS, 32'h3, 32'h1);
      chk(irq, 1'b1);
      wr(PLLC_OFS_IRQ, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      glitch <= 1'b1;
      repeat (2) @(posedge clk);
      glitch <= 1'b0;
      repeat (12) @(posedge clk);
      chk(lock_flag, 1'b1);
      lose <= 1'b1;
      wait_for(0, 1'b0);
      rdc(PLLC_OFS_IRQ, 32'h2, 32'h2);
      lose <= 1'b0;
      wait_for(0, 1'b1);
      // every reference, prompt and slow relock
      for (int s = 0; s < 4; s++) begin
         lock_cyc <= 8'(10 + 40 * s);
         wr(PLLC_OFS_CTRL, 32'(s * 16 + 1));
         wait_for(1, 1'b0);
         wait_for(1, 1'b1);
         chk({ref_clk_select, lock_flag}, {2'(s), 1'b0});
         wait_for(0, 1'b1);
      end
      // product limit at and beyond its boundary
      wr(PLLC_OFS_DIVO, 32'h1);
      wr(PLLC_OFS_DIVFB, 32'h1);
      wr(PLLC_OFS_DIVM, 32'hFF);
      repeat (3) @(posedge clk);
      chk(pll_reset_n, 1'b1);
      wr(PLLC_OFS_DIVFB, 32'h2);
      wait_for(1, 1'b0);
      rdc(PLLC_OFS_STATUS, 32'h2, 32'h2);
      wr(PLLC_OFS_DIVM, 32'h08);
      wait_for(1, 1'b1);
      // every phase code with changing output selection
      for (int c = 0; c < 8; c++) begin
         wr(PLLC_OFS_PHASE, 32'h1000 | (32'(5'h15 ^ 5'(c)) << 4) | c);
         wait_for(2, 1'b1);
         chk({phase_out_select, phase_code}, {5'h15 ^ 5'(c), 3'(c)});
      end
      rdc(PLLC_OFS_IRQ, 32'h4, 32'h4);
      wr(PLLC_OFS_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      wr(PLLC_OFS_MASK, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      wr(PLLC_OFS_IRQ, 32'h7);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk({pll_reset_n, lock_flag, irq, div_mult}, 11'h004);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk({pll_reset_n, lock_flag, avs_waitrequest}, 3'h1);
      final_report;
   end
endmodule
